// ---- rtl/clmtp_regs.svh ----
// Register offsets, field values and timing counts of the position feedback block
`ifndef CLMTP_REGS_SVH
`define CLMTP_REGS_SVH
`define CLMTP_ADDR_W 16
`define CLMTP_OFS_ABS_SET 16'h2015
`define CLMTP_OFS_FB_SEL 16'h2030
`define CLMTP_OFS_EXT_TYPE 16'h2031
`define CLMTP_OFS_EXT_INV 16'h2032
`define CLMTP_OFS_HYB_THR 16'h2033
`define CLMTP_OFS_CLR_TURNS 16'h2034
`define CLMTP_OFS_DIV_NUM 16'h2035
`define CLMTP_OFS_DIV_DEN 16'h2036
`define CLMTP_OFS_EXT_PPR 16'h2037
`define CLMTP_OFS_CTRL_MODE 16'h2001
`define CLMTP_OFS_MT_LIMIT 16'h2663
`define CLMTP_OFS_STATUS 16'h2100
`define CLMTP_OFS_TURNS 16'h2101
`define CLMTP_OFS_SINGLE 16'h2102
`define CLMTP_OFS_HYB_DEV 16'h2103
`define CLMTP_OFS_FB_POS 16'h2104
`define CLMTP_ABS_INCR 16'h0000
`define CLMTP_ABS_LINEAR 16'h0001
`define CLMTP_ABS_ROTARY 16'h0002
`define CLMTP_ABS_SINGLE 16'h0003
`define CLMTP_ABS_CLR_ALM 16'h0005
`define CLMTP_ABS_CLR_MT 16'h0009
`define CLMTP_FB_MOTOR 16'h0000
`define CLMTP_FB_EXT 16'h0001
`define CLMTP_CTRL_FCL 16'h0001
`define CLMTP_EXT_ABZ 16'h0000
`define CLMTP_DEN_RST 32'h0000_2710
`define CLMTP_THR_RST 32'h0000_FFFF
`define CLMTP_CLR_MAX 16'h0064
`define CLMTP_CMD_TIME_MS 3000
`define CLMTP_CLK_MHZ 25
`define CLMTP_CMD_CYC (`CLMTP_CMD_TIME_MS * 1000 * `CLMTP_CLK_MHZ)
`endif

// ---- rtl/clmtp_pkg.sv ----
// Types of the position feedback block
`default_nettype none
package clmtp_pkg;
  typedef enum logic [1:0] {CMD_IDLE, CMD_WAIT} clmtp_cmd_e;
  typedef struct packed {
    logic [15:0] abs_setting;
    logic [15:0] fb_sel;
    logic [15:0] ext_type;
    logic ext_inv;
    logic [31:0] hyb_thr;
    logic [15:0] clr_turns;
    logic [31:0] div_num;
    logic [31:0] div_den;
    logic [31:0] ext_ppr;
    logic [15:0] ctrl_mode;
    logic [15:0] mt_limit;
    logic fb_ext_active;
    logic fcl_active;
    logic [31:0] motor_acc;
    logic [63:0] ext_rem;
    logic [31:0] ext_pos;
    logic [31:0] hyb_dev;
    logic [15:0] turn_clr_cnt;
    logic signed [15:0] turns;
    logic [22:0] single;
    logic [31:0] single_base;
    logic dir_mismatch;
    logic hyb_alarm;
    logic abs_alarm;
    logic ovf_alarm;
    logic single_alarm;
    clmtp_cmd_e cmd_st;
    logic [31:0] cmd_cnt;
    logic [31:0] rdata;
    logic [31:0] fb_pos;
  } clmtp_state_s;
endpackage
`default_nettype wire

// ---- rtl/clmtp_top.sv ----
// Closed loop feedback selection, hybrid deviation and multiturn position
//
// How it works
// RL1 - External type 0..3, only ABZ counts
// RL2 - Flag direction mismatch, optional external inversion
// RL3 - Scale external counts; zero numerator means resolution
// RL4 - Zero PPR uses denominator as per-turn count
// RL5 - Alarm when hybrid deviation exceeds threshold
// RL6 - Clear deviation every N turns, closed loop
// RL7 - Feedback select: motor, external, reserved
// RL8 - Closed loop needs mode 1; restart applies
// RL9 - Mode 0 incremental, effective at once
// RL10 - Single-turn mode alarms outside one revolution
// RL11 - Value 5 clears alarm then multiturn
// RL12 - Value 9 zeroes turns, clears, multiturn
// RL13 - Clockwise decrements, counter-clockwise increments turns
// RL14 - Sixteen-bit signed turns wrap at limits
// RL15 - Single-turn field spans encoder resolution
// RL16 - Linear mode alarms at turn limits
// RL17 - Rotary mode wraps within upper limit
// RL18 - Linear mode flags invalid stored data
// RL19 - Homed and battery good clears alarm
// RL20 - Read position stopped, read twice
// RL21 - Deviation is scaled external minus motor
//
// Chosen here: the strobed register port.
`default_nettype none
`include "clmtp_regs.svh"
module clmtp_top
  import clmtp_pkg::*;
#(
  parameter int ENC_BITS = 23,
  parameter int CMD_CYC = `CLMTP_CMD_CYC
) (
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  input wire logic [`CLMTP_ADDR_W-1:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_MOT_STEP,
  input wire logic I_MOT_DIR_CCW,
  input wire logic I_EXT_STEP,
  input wire logic I_EXT_DIR_UP,
  input wire logic I_RESTART,
  input wire logic I_HOMED,
  input wire logic I_BATT_OK,
  input wire logic I_MT_DATA_INVALID,
  output logic [31:0] O_RDATA,
  output logic [31:0] O_FB_POS,
  output logic signed [15:0] O_TURNS,
  output logic [22:0] O_SINGLE_POS,
  output logic O_DIR_MISMATCH,
  output logic O_HYB_ALARM,
  output logic O_ABS_ALARM,
  output logic O_OVF_ALARM
);
  // ****************************************
  // Local values
  // ****************************************
  localparam logic [31:0] RES = 32'(1) << ENC_BITS;
  localparam logic [22:0] SMAX = 23'(RES - 32'd1);
  localparam logic [31:0] CMD_LAST = 32'(CMD_CYC - 1);

  clmtp_state_s s_r, s_nxt;
  logic [31:0] num_eff;
  logic [31:0] den_eff;
  logic ext_up;
  logic ext_ok;
  logic [63:0] rem_sum;
  logic signed [31:0] ext_delta;
  logic signed [31:0] mot_delta;
  logic signed [31:0] dev_abs;
  logic wrap_up;
  logic wrap_dn;
  logic [15:0] lim;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    // RL3 - zero numerator substitution
    num_eff = (s_r.div_num == 32'h0000_0000) ? RES : s_r.div_num;
    // RL4 - per-turn count choice
    den_eff = (s_r.ext_ppr == 32'h0000_0000) ? s_r.div_den : s_r.ext_ppr;
    if (den_eff == 32'h0000_0000) begin
      den_eff = 32'h0000_0001;
    end
    // RL2 - direction inversion
    ext_up = I_EXT_DIR_UP ^ s_r.ext_inv;
    // RL1 - only ABZ accepted
    ext_ok = I_EXT_STEP && (s_r.ext_type == `CLMTP_EXT_ABZ);
    mot_delta = I_MOT_STEP ? (I_MOT_DIR_CCW ? 32'sd1 : -32'sd1) : 32'sd0;
    ext_delta = 32'sd0;
    rem_sum = s_r.ext_rem;
    // RL3 - fractional scaling, remainder kept
    if (ext_ok) begin
      rem_sum = ext_up ? (s_r.ext_rem + 64'(num_eff)) : (s_r.ext_rem - 64'(num_eff));
    end
    if ($signed(rem_sum) >= $signed(64'(den_eff))) begin
      ext_delta = 32'sd1;
      rem_sum = rem_sum - 64'(den_eff);
    end else if ($signed(rem_sum) <= -$signed(64'(den_eff))) begin
      ext_delta = -32'sd1;
      rem_sum = rem_sum + 64'(den_eff);
    end
    s_nxt.ext_rem = rem_sum;
    s_nxt.ext_pos = s_r.ext_pos + 32'(ext_delta);
    s_nxt.motor_acc = s_r.motor_acc + 32'(mot_delta);
    // RL2 - mismatch seen on simultaneous steps
    if (I_MOT_STEP && ext_ok) begin
      s_nxt.dir_mismatch = (I_MOT_DIR_CCW != ext_up);
    end
    // RL21 - accumulated signed difference
    s_nxt.hyb_dev = s_r.hyb_dev + 32'(ext_delta) - 32'(mot_delta);
    // RL15 - single turn position and turn edge
    wrap_up = 1'b0;
    wrap_dn = 1'b0;
    if (I_MOT_STEP) begin
      if (I_MOT_DIR_CCW) begin
        wrap_up = (s_r.single == SMAX);
        s_nxt.single = wrap_up ? 23'h000000 : s_r.single + 23'h000001;
      end else begin
        wrap_dn = (s_r.single == 23'h000000);
        s_nxt.single = wrap_dn ? SMAX : s_r.single - 23'h000001;
      end
    end
    // RL6 - periodic clear in closed loop
    if ((wrap_up || wrap_dn) && s_r.fcl_active && (s_r.clr_turns != 16'h0000)) begin
      if (s_r.turn_clr_cnt + 16'h0001 >= s_r.clr_turns) begin
        s_nxt.turn_clr_cnt = 16'h0000;
        s_nxt.hyb_dev = 32'(ext_delta) - 32'(mot_delta);
      end else begin
        s_nxt.turn_clr_cnt = s_r.turn_clr_cnt + 16'h0001;
      end
    end
    // RL5 - threshold compare, sticky until clear
    dev_abs = $signed(s_nxt.hyb_dev);
    if (dev_abs < 0) begin
      dev_abs = -dev_abs;
    end
    if (s_r.fcl_active && (dev_abs > $signed(s_r.hyb_thr))) begin
      s_nxt.hyb_alarm = 1'b1;
    end
    // RL13 - turn direction
    // RL14 - native two's complement wrap
    lim = s_r.mt_limit;
    if (wrap_up) begin
      s_nxt.turns = s_r.turns + 16'sd1;
    end else if (wrap_dn) begin
      s_nxt.turns = s_r.turns - 16'sd1;
    end
    case (s_r.abs_setting)
      `CLMTP_ABS_LINEAR: begin
        // RL16 - overflow at either limit
        if ((wrap_up && s_r.turns == 16'sh7FFF) || (wrap_dn && s_r.turns == -16'sh8000)) begin
          s_nxt.ovf_alarm = 1'b1;
        end
      end
      `CLMTP_ABS_ROTARY: begin
        // RL17 - wrap inside 0..limit, no overflow
        if (wrap_up) begin
          s_nxt.turns = (s_r.turns >= $signed(lim)) ? 16'sd0 : s_r.turns + 16'sd1;
        end else if (wrap_dn) begin
          s_nxt.turns = (s_r.turns <= 16'sd0) ? $signed(lim) : s_r.turns - 16'sd1;
        end
      end
      `CLMTP_ABS_SINGLE: begin
        // RL10 - leaving the revolution alarms
        if (wrap_up || wrap_dn) begin
          s_nxt.single_alarm = 1'b1;
          s_nxt.ovf_alarm = 1'b1;
        end
      end
      default: begin
        // RL9 - incremental, no alarms kept
      end
    endcase
    // RL18 - invalid stored data in linear mode
    // Bad data during a clear command keeps the alarm up
    if (((s_r.abs_setting == `CLMTP_ABS_LINEAR) || (s_r.cmd_st == CMD_WAIT)) && I_MT_DATA_INVALID) begin
      s_nxt.abs_alarm = 1'b1;
    end else if (I_HOMED && I_BATT_OK && !I_MT_DATA_INVALID) begin
      // RL19 - homed and battery fine
      s_nxt.abs_alarm = 1'b0;
    end
    // Clear command sequencing
    case (s_r.cmd_st)
      CMD_IDLE: begin
        s_nxt.cmd_cnt = 32'h0000_0000;
      end
      CMD_WAIT: begin
        // RL11 - value stays while alarm persists
        if (!s_nxt.abs_alarm) begin
          s_nxt.abs_setting = `CLMTP_ABS_LINEAR;
          s_nxt.cmd_st = CMD_IDLE;
        end else if (s_r.cmd_cnt < CMD_LAST) begin
          s_nxt.cmd_cnt = s_r.cmd_cnt + 32'h0000_0001;
        end
      end
      default: begin
        s_nxt.cmd_st = CMD_IDLE;
      end
    endcase
    // RL8 - feedback choice latched at restart
    if (I_RESTART) begin
      s_nxt.fcl_active = (s_r.ctrl_mode == `CLMTP_CTRL_FCL) && (s_r.fb_sel == `CLMTP_FB_EXT);
      // RL7 - source select, reserved means motor
      s_nxt.fb_ext_active = s_nxt.fcl_active;
    end
    s_nxt.fb_pos = s_r.fb_ext_active ? s_nxt.ext_pos : s_nxt.motor_acc;
    // ****************************************
    // Register writes
    // ****************************************
    if (I_WR) begin
      case (I_ADDR)
        `CLMTP_OFS_ABS_SET: begin
          s_nxt.abs_setting = I_WDATA[15:0];
          s_nxt.single_alarm = 1'b0;
          s_nxt.ovf_alarm = 1'b0;
          // RL11 - clear alarm command
          if (I_WDATA[15:0] == `CLMTP_ABS_CLR_ALM) begin
            s_nxt.abs_alarm = 1'b0;
            s_nxt.cmd_st = CMD_WAIT;
            s_nxt.cmd_cnt = 32'h0000_0000;
          end
          // RL12 - zero turns command
          if (I_WDATA[15:0] == `CLMTP_ABS_CLR_MT) begin
            s_nxt.turns = 16'sd0;
            s_nxt.abs_alarm = 1'b0;
            s_nxt.cmd_st = CMD_WAIT;
            s_nxt.cmd_cnt = 32'h0000_0000;
          end
        end
        `CLMTP_OFS_FB_SEL: s_nxt.fb_sel = I_WDATA[15:0];
        `CLMTP_OFS_EXT_TYPE: s_nxt.ext_type = I_WDATA[15:0];
        `CLMTP_OFS_EXT_INV: s_nxt.ext_inv = I_WDATA[0];
        `CLMTP_OFS_HYB_THR: s_nxt.hyb_thr = I_WDATA;
        `CLMTP_OFS_CLR_TURNS: s_nxt.clr_turns = (I_WDATA[15:0] > `CLMTP_CLR_MAX) ? `CLMTP_CLR_MAX : I_WDATA[15:0];
        `CLMTP_OFS_DIV_NUM: s_nxt.div_num = I_WDATA;
        `CLMTP_OFS_DIV_DEN: s_nxt.div_den = (I_WDATA == 32'h0000_0000) ? 32'h0000_0001 : I_WDATA;
        `CLMTP_OFS_EXT_PPR: s_nxt.ext_ppr = I_WDATA;
        `CLMTP_OFS_CTRL_MODE: s_nxt.ctrl_mode = I_WDATA[15:0];
        `CLMTP_OFS_MT_LIMIT: s_nxt.mt_limit = I_WDATA[15:0];
        `CLMTP_OFS_STATUS: begin
          // Writing a one to bit 0 clears the deviation alarm and sum
          if (I_WDATA[0]) begin
            s_nxt.hyb_alarm = 1'b0;
            s_nxt.hyb_dev = 32'h0000_0000;
          end
        end
        default: begin
        end
      endcase
    end
    // ****************************************
    // Register reads
    // ****************************************
    s_nxt.rdata = 32'h0000_0000;
    if (I_RD) begin
      case (I_ADDR)
        `CLMTP_OFS_ABS_SET: s_nxt.rdata = {16'h0000, s_r.abs_setting};
        `CLMTP_OFS_FB_SEL: s_nxt.rdata = {16'h0000, s_r.fb_sel};
        `CLMTP_OFS_EXT_TYPE: s_nxt.rdata = {16'h0000, s_r.ext_type};
        `CLMTP_OFS_EXT_INV: s_nxt.rdata = {31'h00000000, s_r.ext_inv};
        `CLMTP_OFS_HYB_THR: s_nxt.rdata = s_r.hyb_thr;
        `CLMTP_OFS_CLR_TURNS: s_nxt.rdata = {16'h0000, s_r.clr_turns};
        `CLMTP_OFS_DIV_NUM: s_nxt.rdata = s_r.div_num;
        `CLMTP_OFS_DIV_DEN: s_nxt.rdata = s_r.div_den;
        `CLMTP_OFS_EXT_PPR: s_nxt.rdata = s_r.ext_ppr;
        `CLMTP_OFS_CTRL_MODE: s_nxt.rdata = {16'h0000, s_r.ctrl_mode};
        `CLMTP_OFS_MT_LIMIT: s_nxt.rdata = {16'h0000, s_r.mt_limit};
        `CLMTP_OFS_STATUS: s_nxt.rdata = {25'h0000000, s_r.fb_ext_active, s_r.fcl_active, s_r.single_alarm,
                                          s_r.ovf_alarm, s_r.abs_alarm, s_r.dir_mismatch, s_r.hyb_alarm};
        // RL20 - no snapshot; software reads twice while stopped
        `CLMTP_OFS_TURNS: s_nxt.rdata = {{16{s_r.turns[15]}}, s_r.turns};
        `CLMTP_OFS_SINGLE: s_nxt.rdata = {9'h000, s_r.single};
        `CLMTP_OFS_HYB_DEV: s_nxt.rdata = s_r.hyb_dev;
        `CLMTP_OFS_FB_POS: s_nxt.rdata = s_r.fb_pos;
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      s_r <= '0;
      s_r.div_den <= `CLMTP_DEN_RST;
      s_r.hyb_thr <= `CLMTP_THR_RST;
      s_r.cmd_st <= CMD_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign O_RDATA = s_r.rdata;
  assign O_FB_POS = s_r.fb_pos;
  assign O_TURNS = s_r.turns;
  assign O_SINGLE_POS = s_r.single;
  assign O_DIR_MISMATCH = s_r.dir_mismatch;
  assign O_HYB_ALARM = s_r.hyb_alarm;
  assign O_ABS_ALARM = s_r.abs_alarm;
  assign O_OVF_ALARM = s_r.ovf_alarm;
endmodule
`default_nettype wire

// ---- testbench/clmtp_top_props.sv ----
// Concurrent checks on the ports of the position feedback block
`default_nettype none
`include "clmtp_regs.svh"
module clmtp_props #(
  parameter int ENC_BITS = 23
) (
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  input wire logic [`CLMTP_ADDR_W-1:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_MOT_STEP,
  input wire logic I_MOT_DIR_CCW,
  input wire logic I_HOMED,
  input wire logic I_BATT_OK,
  input wire logic I_MT_DATA_INVALID,
  input wire logic [31:0] O_RDATA,
  input wire logic signed [15:0] O_TURNS,
  input wire logic [22:0] O_SINGLE_POS,
  input wire logic O_HYB_ALARM,
  input wire logic O_ABS_ALARM,
  input wire logic O_OVF_ALARM
);
  localparam logic [23:0] RES = 24'(2 ** ENC_BITS);
  logic abs_wr;
  assign abs_wr = I_WR && (I_ADDR == `CLMTP_OFS_ABS_SET);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_B);
  property p_rdata_idle; !$past(I_RD) |-> O_RDATA == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside answer cycle");
  property p_cw_turn; (I_MOT_STEP && !I_MOT_DIR_CCW && O_SINGLE_POS == 23'h0 && !abs_wr)
    |=> O_TURNS == $past(O_TURNS) - 16'sh1; endproperty
  a_cw_turn: assert property (p_cw_turn) else $error("clockwise wrap did not decrement turns");
  property p_ccw_turn; (I_MOT_STEP && I_MOT_DIR_CCW && O_SINGLE_POS == 23'(RES - 24'h1) && !abs_wr)
    |=> O_TURNS == $past(O_TURNS) + 16'sh1; endproperty
  a_ccw_turn: assert property (p_ccw_turn) else $error("ccw wrap did not increment turns");
  property p_single_range; {1'b0, O_SINGLE_POS} < RES; endproperty
  a_single_range: assert property (p_single_range) else $error("single-turn position out of range");
  property p_hyb_sticky; O_HYB_ALARM && !(I_WR && I_ADDR == `CLMTP_OFS_STATUS && I_WDATA[0]) |=> O_HYB_ALARM;
  endproperty
  a_hyb_sticky: assert property (p_hyb_sticky) else $error("hybrid alarm dropped without clear");
  property p_ovf_sticky; O_OVF_ALARM && !abs_wr |=> O_OVF_ALARM; endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow alarm dropped without write");
  property p_zero_turns; abs_wr && I_WDATA == 32'h9 && !I_MOT_STEP |-> ##[1:2] O_TURNS == 16'sh0; endproperty
  a_zero_turns: assert property (p_zero_turns) else $error("turns not zeroed by clear command");
  property p_clr_alarm; abs_wr && I_WDATA == 32'h5 && !I_MT_DATA_INVALID |-> ##[1:2] !O_ABS_ALARM; endproperty
  a_clr_alarm: assert property (p_clr_alarm) else $error("alarm clear command ignored");
  property p_homed_ok; (I_HOMED && I_BATT_OK && !I_MT_DATA_INVALID) [*3] |-> !O_ABS_ALARM; endproperty
  a_homed_ok: assert property (p_homed_ok) else $error("absolute alarm stays after homing");
endmodule
bind clmtp_top clmtp_props #(.ENC_BITS(ENC_BITS)) u_props (.I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .I_MOT_STEP(I_MOT_STEP), .I_MOT_DIR_CCW(I_MOT_DIR_CCW),
  .I_HOMED(I_HOMED), .I_BATT_OK(I_BATT_OK), .I_MT_DATA_INVALID(I_MT_DATA_INVALID), .O_RDATA(O_RDATA),
  .O_TURNS(O_TURNS), .O_SINGLE_POS(O_SINGLE_POS), .O_HYB_ALARM(O_HYB_ALARM), .O_ABS_ALARM(O_ABS_ALARM),
  .O_OVF_ALARM(O_OVF_ALARM));
`default_nettype wire

// ---- testbench/clmtp_enc_model.sv ----
// Motor encoder and external scale count sources
`default_nettype none
module clmtp_enc_model (
  input wire logic i_mclk,
  output logic o_mot_step,
  output logic o_mot_dir_ccw,
  output logic o_ext_step,
  output logic o_ext_dir_up
);
  initial begin
    o_mot_step = 1'b0;
    o_mot_dir_ccw = 1'b0;
    o_ext_step = 1'b0;
    o_ext_dir_up = 1'b0;
  end
  // direction sense, one count per cycle
  task automatic move(input int n, input logic mot, input logic ccw, input logic ext, input logic up);
    @(posedge i_mclk);
    o_mot_step <= mot;
    o_mot_dir_ccw <= ccw;
    o_ext_step <= ext;
    o_ext_dir_up <= up;
    repeat (n) @(posedge i_mclk);
    o_mot_step <= 1'b0;
    o_ext_step <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench of the position feedback block
`default_nettype none
`include "clmtp_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Short revolution keeps wrap scenarios brief
  localparam int ENC = 4;
  logic mclk, rst_b, wr, rd, restart, homed, batt_ok, mt_inv;
  logic [15:0] addr;
  logic [31:0] wdata, rdata, fb_pos, rv;
  logic signed [15:0] turns;
  logic [22:0] single;
  logic mot_step, mot_ccw, ext_step, ext_up, dir_mm, hyb_alm, abs_alm, ovf_alm;
  int num_errors = 0;
  int total_checks = 0;
  clmtp_enc_model u_enc (.i_mclk(mclk), .o_mot_step(mot_step), .o_mot_dir_ccw(mot_ccw), .o_ext_step(ext_step),
    .o_ext_dir_up(ext_up));
  clmtp_top #(.ENC_BITS(ENC), .CMD_CYC(100)) DUT (.I_MCLK(mclk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .I_MOT_STEP(mot_step), .I_MOT_DIR_CCW(mot_ccw), .I_EXT_STEP(ext_step),
    .I_EXT_DIR_UP(ext_up), .I_RESTART(restart), .I_HOMED(homed), .I_BATT_OK(batt_ok),
    .I_MT_DATA_INVALID(mt_inv), .O_RDATA(rdata), .O_FB_POS(fb_pos), .O_TURNS(turns), .O_SINGLE_POS(single),
    .O_DIR_MISMATCH(dir_mm), .O_HYB_ALARM(hyb_alm), .O_ABS_ALARM(abs_alm), .O_OVF_ALARM(ovf_alm));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    rd_reg(a, d);
    chk(what, d, exp);
  endtask
  task automatic tally_and_finish();
    $display("Checks made %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #2_000_000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    {wr, rd, restart, homed, batt_ok, mt_inv} = 6'h0;
    addr = 16'h0;
    wdata = 32'h0;
    rst_b = 1'b0;
    cyc(10);
    rst_b <= 1'b1;
    rd_chk(`CLMTP_OFS_DIV_DEN, 32'h0000_2710, "den reset");
    rd_chk(`CLMTP_OFS_HYB_THR, 32'h0000_FFFF, "thr reset");
    rd_chk(`CLMTP_OFS_ABS_SET, 32'h0, "abs reset");
    wr_reg(16'h2222, 32'hFFFF_FFFF);
    rd_chk(16'h2222, 32'h0, "unmapped");
    $display("Test registers done");
    u_enc.move(1, 1'b1, 1'b0, 1'b0, 1'b0);
    cyc(2);
    chk("turns cw", 32'(turns), 32'hFFFF_FFFF);
    chk("single cw", 32'(single), 32'hF);
    u_enc.move(17, 1'b1, 1'b1, 1'b0, 1'b0);
    cyc(2);
    rd_chk(`CLMTP_OFS_TURNS, 32'h1, "turns read 1");
    rd_chk(`CLMTP_OFS_TURNS, 32'h1, "turns read 2");
    chk("single ccw", 32'(single), 32'h0);
    $display("Test turns done");
    wr_reg(`CLMTP_OFS_ABS_SET, 32'h9);
    cyc(4);
    chk("turns zero", 32'(turns), 32'h0);
    rd_chk(`CLMTP_OFS_ABS_SET, 32'h1, "abs after 9");
    mt_inv <= 1'b1;
    cyc(3);
    chk("abs alarm", 32'(abs_alm), 32'h1);
    wr_reg(`CLMTP_OFS_ABS_SET, 32'h5);
    cyc(150);
    rd_chk(`CLMTP_OFS_ABS_SET, 32'h5, "abs stays 5");
    mt_inv <= 1'b0;
    homed <= 1'b1;
    batt_ok <= 1'b1;
    cyc(5);
    chk("abs cleared", 32'(abs_alm), 32'h0);
    rd_chk(`CLMTP_OFS_ABS_SET, 32'h1, "abs after 5");
    wr_reg(`CLMTP_OFS_ABS_SET, 32'h5);
    $display("Test absolute commands done");
    wr_reg(`CLMTP_OFS_ABS_SET, 32'h3);
    u_enc.move(1, 1'b1, 1'b0, 1'b0, 1'b0);
    cyc(2);
    chk("single out", 32'(ovf_alm), 32'h1);
    wr_reg(`CLMTP_OFS_ABS_SET, 32'h0);
    cyc(2);
    chk("mode 0 at once", 32'(ovf_alm), 32'h0);
    $display("Test single turn done");
    wr_reg(`CLMTP_OFS_DIV_NUM, 32'h1);
    wr_reg(`CLMTP_OFS_DIV_DEN, 32'h2);
    wr_reg(`CLMTP_OFS_HYB_THR, 32'h1);
    wr_reg(`CLMTP_OFS_CLR_TURNS, 32'h1);
    wr_reg(`CLMTP_OFS_CTRL_MODE, 32'h1);
    wr_reg(`CLMTP_OFS_FB_SEL, 32'h1);
    rd_reg(`CLMTP_OFS_STATUS, rv);
    chk("fcl before restart", 32'(rv[5]), 32'h0);
    @(posedge mclk);
    restart <= 1'b1;
    @(posedge mclk);
    restart <= 1'b0;
    rd_reg(`CLMTP_OFS_STATUS, rv);
    chk("fcl after restart", 32'(rv[6:5]), 32'h3);
    wr_reg(`CLMTP_OFS_STATUS, 32'h1);
    u_enc.move(4, 1'b0, 1'b0, 1'b1, 1'b1);
    cyc(3);
    chk("fb scaled", fb_pos, 32'h2);
    rd_chk(`CLMTP_OFS_HYB_DEV, 32'h2, "hyb dev");
    chk("hyb alarm", 32'(hyb_alm), 32'h1);
    u_enc.move(1, 1'b1, 1'b1, 1'b0, 1'b0);
    cyc(3);
    rd_chk(`CLMTP_OFS_HYB_DEV, 32'hFFFF_FFFF, "periodic clear");
    wr_reg(`CLMTP_OFS_EXT_TYPE, 32'h1);
    u_enc.move(4, 1'b0, 1'b0, 1'b1, 1'b1);
    cyc(3);
    chk("type 1 ignored", fb_pos, 32'h2);
    wr_reg(`CLMTP_OFS_EXT_TYPE, 32'h0);
    $display("Test closed loop done");
    u_enc.move(2, 1'b1, 1'b1, 1'b1, 1'b0);
    #1;
    chk("dir mismatch", 32'(dir_mm), 32'h1);
    wr_reg(`CLMTP_OFS_EXT_INV, 32'h1);
    u_enc.move(2, 1'b1, 1'b1, 1'b1, 1'b0);
    #1;
    chk("dir inverted", 32'(dir_mm), 32'h0);
    $display("Test direction done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
